// *** ofp_pkg.sv ***
// Package of constants and carrier types for the octal flash read-capture block.
`default_nettype none
package ofp_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ    = 10_000_000;  // Core clock rate.
	localparam int unsigned SCK_HZ    = 1_250_000;   // Flash clock rate, one byte per beat.
	localparam int unsigned PERIOD    = CLK_HZ / SCK_HZ;
	localparam logic [2:0]  PH_LAST   = 3'(PERIOD - 1);
	localparam logic [2:0]  PH_HALF   = 3'(PERIOD / 2);
	localparam logic [2:0]  PH_SAMPLE = PH_HALF;     // Internal-clock sample point.
	localparam logic [3:0]  WIN_LEN   = 4'h3;        // Width of the sampling window in cycles.
	localparam int unsigned DLY_LEN   = 16;          // Taps of the transmit and receive delay lines.

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_DELAY  = 8'h04;
	localparam logic [7:0]  ADR_CMD    = 8'h08;
	localparam logic [7:0]  ADR_STATUS = 8'h0c;
	localparam logic [7:0]  ADR_WDATA  = 8'h10;
	localparam logic [7:0]  ADR_RDATA  = 8'h14;
	localparam logic [31:0] RST_REG    = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK  = 32'h0000_0007;
	localparam logic [31:0] DELAY_MASK = 32'h0000_0ff7;
	localparam logic [31:0] CMD_MASK   = 32'h0000_ffff;
	localparam int unsigned CTRL_PHY   = 0;
	localparam int unsigned CTRL_PIPE  = 1;
	localparam int unsigned CTRL_POLL  = 2;
	localparam int unsigned RD_LO      = 0;
	localparam int unsigned TX_LO      = 4;
	localparam int unsigned RX_LO      = 8;
	localparam int unsigned OPC_LO     = 0;
	localparam int unsigned NBY_LO     = 8;
	localparam int unsigned CMD_WR     = 11;
	localparam int unsigned PAD_LO     = 12;
	localparam int unsigned CMD_START  = 16;
	localparam int unsigned ST_BUSY    = 0;
	localparam int unsigned ST_WINERR  = 1;
	localparam int unsigned ST_POLLOFF = 2;
	localparam int unsigned ST_FLBUSY  = 3;

	// ****************************************************************
	// Flash status polling
	// ****************************************************************
	localparam logic [7:0]  POLL_OPC    = 8'h05;  // Read-status opcode used by the poller.
	localparam int unsigned FL_BUSY_BIT = 0;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [3:0] rx_dly;
		logic [3:0] tx_dly;
		logic [2:0] rd_dly;
		logic       autopoll_en;
		logic       pipe_en;
		logic       phy_en;
	} ofp_cfg_s;

	typedef struct packed {
		logic       vld;
		logic       err;
		logic [7:0] data;
	} ofp_cap_s;
endpackage : ofp_pkg
`default_nettype wire

// *** ofp_capture.sv ***
// Strobe capture front end: samples read bytes by strobe or internal clock.
`timescale 1ns/1ns
`default_nettype none
module ofp_capture
	import ofp_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Configuration and beat timing.
	input  wire ofp_cfg_s   cfg,
	input  wire logic       rx_en,
	input  wire logic [2:0] ph,
	// Flash data and strobe.
	input  wire logic [7:0] dq_i,
	input  wire logic       dqs_i,
	// Captured byte.
	output var ofp_cap_s    cap
);
	logic                 dqs_q;
	logic                 dqs_d;
	logic [DLY_LEN-1:0]   edl_q;
	logic [DLY_LEN-1:0]   edl_d;
	ofp_cap_s             s1_q;
	ofp_cap_s             s1_d;
	ofp_cap_s             out_d;
	logic                 edge_now;
	logic                 edge_dl;
	logic [3:0]           win_lo;
	logic                 in_win;

	// Rising strobe edge, delayed by the receive delay taps, then windowed.
	always_comb begin
		dqs_d    = dqs_i;
		edge_now = dqs_i && !dqs_q;
		edl_d    = {edl_q[DLY_LEN-2:0], edge_now};
		edge_dl  = (cfg.rx_dly == 4'h0) ? edge_now : edl_q[cfg.rx_dly - 4'h1];
		win_lo   = {1'b0, cfg.rd_dly};
		// A larger read delay moves the window later in the beat.
		in_win   = ({1'b0, ph} >= win_lo) && ({1'b0, ph} < win_lo + WIN_LEN); // R04
		s1_d     = '0;
		if (cfg.phy_en) begin
			s1_d.vld  = rx_en && edge_dl && in_win; // R01
			s1_d.err  = rx_en && edge_dl && !in_win; // R02
		end else begin
			s1_d.vld  = rx_en && (ph == PH_SAMPLE);
		end
		s1_d.data = dq_i;
		// Pipelined capture adds one register stage.
		out_d = cfg.pipe_en ? s1_q : s1_d;
	end

	// Capture registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dqs_q <= 1'b0;
			edl_q <= '0;
			s1_q  <= '0;
			cap   <= '0;
		end else begin
			dqs_q <= dqs_d;
			edl_q <= edl_d;
			s1_q  <= s1_d;
			cap   <= out_d;
		end
	end
endmodule : ofp_capture
`default_nettype wire

// *** ofp_flash_top.sv ***
// Octal flash controller with strobe capture, delay tuning and busy polling.
// Summary of operation
// R01: With the capture front end enabled, read bytes are taken on the flash strobe.
// R02: A strobe capture outside the internal-clock window is invalid and flagged.
// R03: Software tunes transmit, receive and read sample delays for robust reads.
// R04: Raising the read sample delay moves the sampling window later in the beat.
// R05: Software enables pipelined capture for every read under the delay shift.
// R06: Software disables pipelined capture for writes; reads and writes are separate.
// R07: Under the delay shift, hardware busy polling is suppressed; software polls.
// R08: Software issues writes as single-page transfers under the delay shift.
// R09: Software polls flash busy between page writes before starting the next.
// R10: With the front end bypassed, hardware busy polling after writes stays usable.
// R11: Software-path reads add pad bytes; software shifts the result right.
// R12: Front end, pipelining and busy polling have separate control bits.
`timescale 1ns/1ns
`default_nettype none
module ofp_flash_top
	import ofp_pkg::*;
(
	// Clock and asynchronous reset.
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	// Wishbone slave.
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Flash link.
	output logic             FL_SCK,
	output logic             FL_CS_N,
	output logic      [7:0]  FL_DQ_O,
	output logic             FL_DQ_OE,
	input  wire logic [7:0]  FL_DQ_I,
	input  wire logic        FL_DQS
);
	typedef enum {
		S_IDLE, S_ARM, S_CMD, S_TX, S_RX, S_DRAIN, S_PGAP, S_PCMD, S_PRX, S_PCHK
	} ofp_state_e;
	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;
	// Two flip-flops release the reset to the core clock.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [31:0]        ctrl_q, ctrl_d;
	logic [31:0]        dly_q, dly_d;
	logic [31:0]        cmd_q, cmd_d;
	logic [31:0]        wdata_q, wdata_d;
	logic               winerr_q, winerr_d;
	logic               ack_q, ack_d;
	logic [31:0]        dat_q, dat_d;
	logic               start;
	logic               req;
	logic               wr_en;
	logic [31:0]        status_w;
	ofp_cfg_s           cfg;
	ofp_cap_s           cap;
	logic               busy;
	logic               poll_off;
	logic               autopoll_eff;
	ofp_state_e         st_q, st_d;
	logic [4:0]         beat_q, beat_d;
	logic [2:0]         ph_q, ph_d;
	logic [7:0]         dq_o_q, dq_o_d;
	logic               dq_oe_q, dq_oe_d;
	logic               cs_n_q, cs_n_d;
	logic [DLY_LEN-1:0] sck_ln_q, sck_ln_d;
	logic [31:0]        rdata_q, rdata_d;
	logic [7:0]         fstat_q, fstat_d;
	logic               tick;
	logic [4:0]         total;
	logic [2:0]         nby;
	// Merge a write into a register under the byte lane selects.
	function automatic logic [31:0] merge(input logic [31:0] old_v, new_v, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			old_v[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
		return old_v;
	endfunction : merge
	// ****************************************************************
	// Configuration and status views
	// ****************************************************************
	// Each control is its own bit so software can reconfigure between transfers.
	always_comb begin
		cfg.phy_en      = ctrl_q[CTRL_PHY]; // R12
		cfg.pipe_en     = ctrl_q[CTRL_PIPE]; // R12
		cfg.autopoll_en = ctrl_q[CTRL_POLL]; // R12
		cfg.rd_dly      = dly_q[RD_LO +: 3];
		cfg.tx_dly      = dly_q[TX_LO +: 4];
		cfg.rx_dly      = dly_q[RX_LO +: 4];
	end
	// Hardware polling is unreliable with a shifted read window, so it is held off.
	assign poll_off     = cfg.autopoll_en && cfg.phy_en && (cfg.rd_dly != 3'h0); // R07
	assign autopoll_eff = cfg.autopoll_en && !poll_off; // R10
	assign busy         = (st_q != S_IDLE);
	assign req          = WB_CYC_I && WB_STB_I;
	assign wr_en        = req && ack_q && WB_WE_I;
	// Status word seen by software.
	always_comb begin
		status_w             = '0;
		status_w[ST_BUSY]    = busy;
		status_w[ST_WINERR]  = winerr_q;
		status_w[ST_POLLOFF] = poll_off;
		status_w[ST_FLBUSY]  = fstat_q[FL_BUSY_BIT];
	end
	// ****************************************************************
	// Wishbone register file
	// ****************************************************************
	// Answer one cycle after the request; writes land on the acknowledged edge.
	always_comb begin
		ctrl_d   = ctrl_q;
		dly_d    = dly_q;
		cmd_d    = cmd_q;
		wdata_d  = wdata_q;
		dat_d    = dat_q;
		start    = 1'b0;
		ack_d    = req && !ack_q;
		winerr_d = winerr_q;
		if (req && !ack_q) begin
			case (WB_ADR_I)
				ADR_CTRL:   dat_d = ctrl_q;
				ADR_DELAY:  dat_d = dly_q;
				ADR_CMD:    dat_d = cmd_q;
				ADR_STATUS: dat_d = status_w;
				ADR_WDATA:  dat_d = wdata_q;
				ADR_RDATA:  dat_d = rdata_q;
				default:    dat_d = RST_REG;
			endcase
		end
		if (wr_en) begin
			case (WB_ADR_I)
				ADR_CTRL:   ctrl_d  = merge(ctrl_q, WB_DAT_I, WB_SEL_I) & CTRL_MASK;
				ADR_DELAY:  dly_d   = merge(dly_q, WB_DAT_I, WB_SEL_I) & DELAY_MASK;
				ADR_WDATA:  wdata_d = merge(wdata_q, WB_DAT_I, WB_SEL_I);
				ADR_CMD: begin
					if (!busy) begin // A command written mid-transfer is ignored.
						cmd_d = merge(cmd_q, WB_DAT_I, WB_SEL_I) & CMD_MASK;
						start = WB_SEL_I[2] && WB_DAT_I[CMD_START];
					end
				end
				ADR_STATUS: winerr_d = winerr_q && !(WB_SEL_I[0] && WB_DAT_I[ST_WINERR]);
				default: begin
				end
			endcase
		end
		// A new window error wins over a clear in the same cycle.
		winerr_d = winerr_d || cap.err; // R02
	end
	// Register file flip-flops.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= RST_REG;
			dly_q    <= RST_REG;
			cmd_q    <= RST_REG;
			wdata_q  <= RST_REG;
			dat_q    <= RST_REG;
			ack_q    <= 1'b0;
			winerr_q <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			dly_q    <= dly_d;
			cmd_q    <= cmd_d;
			wdata_q  <= wdata_d;
			dat_q    <= dat_d;
			ack_q    <= ack_d;
			winerr_q <= winerr_d;
		end
	end
	// ****************************************************************
	// Transfer sequencer
	// ****************************************************************
	// Read length counts pad bytes as well, so the data arrives shifted.
	assign nby   = cmd_q[NBY_LO +: 3];
	assign total = {2'b00, nby} + {1'b0, cmd_q[PAD_LO +: 4]}; // R11
	assign tick  = (ph_q == PH_LAST);
	// Beat timing, state moves, launch data and received bytes.
	always_comb begin
		st_d    = st_q;
		beat_d  = beat_q;
		ph_d    = tick ? 3'h0 : ph_q + 3'h1;
		rdata_d = rdata_q;
		fstat_d = fstat_q;
		if (start) begin
			st_d = S_ARM;
		end else if (tick) begin
			beat_d = 5'h00;
			case (st_q)
				S_ARM:   st_d = S_CMD;
				S_CMD: begin
					if (cmd_q[CMD_WR]) begin
						st_d = (nby != 3'h0) ? S_TX : (autopoll_eff ? S_PGAP : S_DRAIN);
					end else begin
						st_d = (total != 5'h00) ? S_RX : S_DRAIN;
					end
				end
				S_TX: begin
					beat_d = beat_q + 5'h01;
					if (beat_q == {2'b00, nby} - 5'h01) begin
						// Hardware busy polling only when it is trustworthy.
						st_d = autopoll_eff ? S_PGAP : S_DRAIN; // R10
					end
				end
				S_RX: begin
					beat_d = beat_q + 5'h01;
					if (beat_q == total - 5'h01) begin
						st_d = S_DRAIN;
					end
				end
				S_PGAP:  st_d = S_PCMD;
				S_PCMD:  st_d = S_PRX;
				S_PRX:   st_d = S_PCHK;
				S_PCHK:  st_d = fstat_q[FL_BUSY_BIT] ? S_PGAP : S_IDLE;
				S_DRAIN: st_d = S_IDLE;
				default: st_d = S_IDLE;
			endcase
		end
		// Capture results go to the read word or to the flash status byte.
		if (cap.vld) begin
			if (st_q == S_PRX || st_q == S_PCHK) begin
				fstat_d = cap.data;
			end else begin
				rdata_d = {cap.data, rdata_q[31:8]};
			end
		end
		// Pins follow the next state so they change on the beat boundary.
		cs_n_d  = (st_d == S_IDLE) || (st_d == S_ARM) || (st_d == S_DRAIN) ||
			(st_d == S_PGAP) || (st_d == S_PCHK);
		dq_oe_d = (st_d == S_CMD) || (st_d == S_TX) || (st_d == S_PCMD);
		case (st_d)
			S_CMD:   dq_o_d = cmd_q[OPC_LO +: 8];
			S_TX:    dq_o_d = wdata_q[{beat_d[1:0], 3'b000} +: 8];
			S_PCMD:  dq_o_d = POLL_OPC;
			default: dq_o_d = 8'h00;
		endcase
		// Clock high in the first half of each active beat, then delayed.
		sck_ln_d = {sck_ln_q[DLY_LEN-2:0], !cs_n_q && (ph_q < PH_HALF)};
	end
	// Sequencer flip-flops.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= S_IDLE;
			beat_q   <= 5'h00;
			ph_q     <= 3'h0;
			dq_o_q   <= 8'h00;
			dq_oe_q  <= 1'b0;
			cs_n_q   <= 1'b1;
			sck_ln_q <= '0;
			rdata_q  <= RST_REG;
			fstat_q  <= 8'h00;
		end else begin
			st_q     <= st_d;
			beat_q   <= beat_d;
			ph_q     <= ph_d;
			dq_o_q   <= dq_o_d;
			dq_oe_q  <= dq_oe_d;
			cs_n_q   <= cs_n_d;
			sck_ln_q <= sck_ln_d;
			rdata_q  <= rdata_d;
			fstat_q  <= fstat_d;
		end
	end
	// ****************************************************************
	// Capture front end and outputs
	// ****************************************************************
	ofp_capture u_capture (
		.clk   (CORE_CLK),
		.rst_n (rst_n),
		.cfg   (cfg),
		.rx_en ((st_q == S_RX) || (st_q == S_PRX)),
		.ph    (ph_q),
		.dq_i  (FL_DQ_I),
		.dqs_i (FL_DQS),
		.cap   (cap)
	);
	// The transmit delay picks a tap of the clock delay line.
	assign FL_SCK   = sck_ln_q[cfg.tx_dly];
	assign FL_CS_N  = cs_n_q;
	assign FL_DQ_O  = dq_o_q;
	assign FL_DQ_OE = dq_oe_q;
	assign WB_DAT_O = dat_q;
	assign WB_ACK_O = ack_q;
endmodule : ofp_flash_top
`default_nettype wire

// *** ofp_chk_sva.sv ***
// Checker of bus and flash-link timing at the top-level ports.
`timescale 1ns/1ns
`default_nettype none
module ofp_chk_sva (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// Watched bus and link signals.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic FL_CS_N,
	input wire logic FL_DQ_OE
);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);

	// Every register request is answered after exactly one cycle.
	AST_ACK_RESP: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("register request not acknowledged in one cycle");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge longer than one cycle");
	AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_STB_I) && $past(WB_CYC_I))
		else $error("acknowledge without a request");
	// The controller drives the data lines only inside a frame.
	AST_OE_CS: assert property (FL_DQ_OE |-> !FL_CS_N)
		else $error("data lines driven while deselected");
	AST_OE_BEAT: assert property ($rose(FL_DQ_OE) |-> FL_DQ_OE [*8])
		else $error("driven beat shorter than eight cycles");
	// A frame opens with a driven command beat.
	AST_CS_OPC: assert property ($fell(FL_CS_N) |-> FL_DQ_OE)
		else $error("frame opened without command byte");
	AST_CS_BEAT: assert property ($fell(FL_CS_N) |-> !FL_CS_N [*8])
		else $error("frame shorter than one beat");
	// A receive beat leaves the lines to the flash for a whole beat.
	AST_RX_BEAT: assert property ($fell(FL_DQ_OE) && !FL_CS_N |-> !FL_DQ_OE [*8])
		else $error("receive beat cut short");
endmodule : ofp_chk_sva

bind ofp_flash_top ofp_chk_sva chk_u (
	.CORE_CLK(CORE_CLK),
	.ARST_N  (ARST_N),
	.WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O),
	.FL_CS_N (FL_CS_N),
	.FL_DQ_OE(FL_DQ_OE)
);
`default_nettype wire

// *** ofp_flash_model.sv ***
// Behavioural octal flash: numbered read bytes, status byte and write busy.
`timescale 1ns/1ns
`default_nettype none
module ofp_flash_model import ofp_pkg::*; (
	// Core clock that times the replies.
	input  wire logic       clk,
	// Link from the controller.
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [7:0] dq_o,
	input  wire logic       dq_oe,
	// Replies to the controller.
	output logic      [7:0] dq_i,
	output logic            dqs
);
	logic        sck_q, wr;
	logic [7:0]  opc;
	logic [3:0]  bcnt, tcnt;
	logic [1:0]  bsy;
	logic [15:0] wd;

	// ****************************************************************
	// Beat handling
	// ****************************************************************
	// Idle state at start; bytes are {frame number, beat number}.
	initial begin
		{sck_q, wr, opc, bcnt, tcnt, bsy, wd, dq_i, dqs} = '0;
	end
	// Released lines churn so a stale byte never looks valid.
	always @(posedge clk) begin
		sck_q <= sck;
		if (cs_n) begin
			if (bcnt != 4'h0) begin
				tcnt <= tcnt + 4'h1;
				if (wr) bsy <= 2'h2;
				wr <= 1'b0;
			end
			bcnt <= 4'h0;
			dqs  <= 1'b0;
			dq_i <= ~dq_i;
		end else if (sck && !sck_q) begin
			bcnt <= bcnt + 4'h1;
			if (dq_oe) begin
				if (bcnt == 4'h0) opc <= dq_o;
				else begin
					wr <= 1'b1;
					wd <= {dq_o, wd[15:8]};
				end
			end else begin
				dqs <= 1'b1;
				if (opc == POLL_OPC) begin
					dq_i <= {7'h0, bsy != 2'h0};
					if (bsy != 2'h0) bsy <= bsy - 2'h1;
				end else dq_i <= {tcnt, bcnt};
			end
		end else if (!sck && sck_q) dqs <= 1'b0;
	end
endmodule : ofp_flash_model
`default_nettype wire

// *** ofp_tb.sv ***
// Self-checking bench for the octal flash controller.
`timescale 1ns/1ns
`default_nettype none
module testbench import ofp_pkg::*;;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} ofp_row_s;
	logic        clk, arst_n, cyc, stb, we, ack, sck, cs_n, oe, dqs;
	logic [7:0]  adr, dqo, dqi;
	logic [31:0] wdat, rdat, q, s, prev;
	logic [3:0]  t, sel;
	int          errors = 0, tests_run = 0, n, first, last, bad;
	// Reset values, masks and an unmapped address.
	ofp_row_s rows [13] = '{'{0, ADR_CTRL, 0, RST_REG}, '{0, ADR_DELAY, 0, RST_REG},
		'{0, ADR_STATUS, 0, RST_REG}, '{0, ADR_RDATA, 0, RST_REG}, '{0, 8'h18, 0, 0},
		'{1, ADR_CTRL, 32'hff, 0}, '{0, ADR_CTRL, 0, CTRL_MASK}, '{1, ADR_DELAY, '1, 0},
		'{0, ADR_DELAY, 0, DELAY_MASK}, '{1, 8'h18, '1, 0}, '{0, 8'h18, 0, 0},
		'{1, ADR_CTRL, 0, 0}, '{1, ADR_DELAY, 0, 0}};

	// ****************************************************************
	// Design, flash and clock
	// ****************************************************************
	ofp_flash_top dut_u (.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .FL_SCK(sck), .FL_CS_N(cs_n), .FL_DQ_O(dqo), .FL_DQ_OE(oe),
		.FL_DQ_I(dqi), .FL_DQS(dqs));
	ofp_flash_model fl_u (.clk(clk), .sck(sck), .cs_n(cs_n), .dq_o(dqo), .dq_oe(oe),
		.dq_i(dqi), .dqs(dqs));
	// Free-running core clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// One classic cycle; data is taken at the edge that sees ack.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		{cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hf, a, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Starts a command and waits for the controller to go idle.
	task automatic run(input logic [15:0] c);
		logic [31:0] r;
		int k = 0;
		wb(1'b1, ADR_CMD, {15'h0, 1'b1, c}, r);
		do begin
			wb(1'b0, ADR_STATUS, 0, r);
			k++;
		end while (r[ST_BUSY] !== 1'b0 && k < 200);
		if (k >= 200) begin
			errors++;
			stop_test();
		end
	endtask : run
	task automatic stop_test();
		$display("checks=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{cyc, stb, we, sel, adr, wdat, arst_n} = '0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d, q);
			if (!rows[i].w) chk(q, rows[i].x);
		end
		// Internal-clock read with one pad byte.
		run({4'h1, 1'b0, 3'h2, 8'h0b});
		wb(1'b0, ADR_RDATA, 0, q);
		chk(q, 32'h0302_0100);
		// Strobe capture with pipelining, sweeping the sample delay.
		wb(1'b1, ADR_CTRL, 32'h3, q);
		{first, last, bad, prev, t} = {-32'sd1, -32'sd1, 32'd0, 32'h0302_0100, 4'h1};
		for (int r = 0; r < 8; r++) begin
			wb(1'b1, ADR_DELAY, r, q);
			wb(1'b1, ADR_STATUS, 32'h2, q);
			run({4'h0, 1'b0, 3'h1, 8'h0b});
			wb(1'b0, ADR_STATUS, 0, s);
			wb(1'b0, ADR_RDATA, 0, q);
			if (s[ST_WINERR] === 1'b1) begin
				bad++;
				chk(q, prev);
			end else begin
				prev = {t, 4'h1, prev[31:8]};
				chk(q, prev);
				if (last >= 0 && last != r - 1) errors++;
				if (first < 0) first = r;
				last = r;
			end
			t++;
		end
		chk({31'h0, first >= 0 && last - first < 3 && bad > 0}, 32'h1);
		// Busy polling control bits.
		wb(1'b1, ADR_CTRL, 32'h5, q);
		wb(1'b1, ADR_DELAY, 32'h0, q);
		wb(1'b0, ADR_STATUS, 0, s);
		chk({31'h0, s[ST_POLLOFF]}, 32'h0);
		wb(1'b1, ADR_DELAY, last, q);
		wb(1'b0, ADR_STATUS, 0, s);
		chk({31'h0, s[ST_POLLOFF]}, 32'h1);
		// Internal-clock write; hardware polls until the flash is idle.
		wb(1'b1, ADR_CTRL, 32'h4, q);
		wb(1'b1, ADR_WDATA, 32'h0000_2211, q);
		run({4'h0, 1'b1, 3'h2, 8'h02});
		wb(1'b0, ADR_STATUS, 0, s);
		chk({16'h0, fl_u.wd}, 32'h2211);
		chk({30'h0, fl_u.bsy}, 32'h0);
		chk({31'h0, s[ST_FLBUSY]}, 32'h0);
		// Strobe-mode page write, then software polling with pipelined reads.
		wb(1'b1, ADR_CTRL, 32'h5, q);
		wb(1'b1, ADR_WDATA, 32'h55, q);
		run({4'h0, 1'b1, 3'h1, 8'h02});
		wb(1'b1, ADR_CTRL, 32'h7, q);
		n = 0;
		do begin
			run({4'h0, 1'b0, 3'h1, POLL_OPC});
			wb(1'b0, ADR_RDATA, 0, q);
			n++;
		end while (q[24] !== 1'b0 && n < 8);
		chk(n, 32'h3);
		// Receive delay pushes the strobe edge past a window that opens at phase zero.
		wb(1'b1, ADR_DELAY, 32'h100, q);
		wb(1'b1, ADR_STATUS, 32'h2, q);
		run({4'h0, 1'b0, 3'h1, 8'h0b});
		wb(1'b0, ADR_STATUS, 0, s);
		chk({31'h0, s[ST_WINERR]}, 32'h1);
		// Reset once the controller is idle: outputs go idle at once, registers return to reset values.
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({30'h0, ack, cs_n}, 32'h1);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		wb(1'b0, ADR_CTRL, 0, q);
		chk(q, RST_REG);
		wb(1'b0, ADR_STATUS, 0, s);
		chk(s, RST_REG);
		stop_test();
	end
	// Watchdog against a hung handshake.
	initial begin
		#(20000 * 100);
		errors++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
